/* File: combiner_pkg.sv */
package combiner_pkg;
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] force_off = 8'h04;
    localparam logic [7:0] atten_off = 8'h08;
    localparam logic [7:0] offset1_off = 8'h0c;
    localparam logic [7:0] offset2_off = 8'h10;
    localparam logic [7:0] offset3_off = 8'h14;
    localparam logic [7:0] equalize_off = 8'h18;
    localparam logic [7:0] status_off = 8'h1c;
    localparam logic [7:0] mask_off = 8'h20;
    localparam logic [7:0] inputs_off = 8'h24;
    localparam logic [7:0] force_pair_12 = 8'h0c;
    localparam logic [7:0] force_pair_13 = 8'h0d;
    localparam logic [7:0] force_pair_23 = 8'h17;
    localparam logic [2:0] pair_12_on = 3'h3;
    localparam logic [2:0] pair_13_on = 3'h5;
    localparam logic [2:0] pair_23_on = 3'h6;
    localparam int combine_bit = 0;
    localparam int start_bit = 0;
    localparam int st_switch = 0;
    localparam int st_summary = 1;
    localparam int st_amp_lo = 2;
    localparam int st_equalize = 5;
    localparam int status_w = 6;
    localparam logic ctrl_reset = 1'b1;
    localparam logic [7:0] force_reset = force_pair_12;
    localparam logic [15:0] atten_reset = 16'h0000;
    localparam logic [15:0] offset_reset = 16'h0000;
    localparam logic [status_w-1:0] mask_reset = 6'h00;
    localparam int blink_half_ms = 500;
    localparam int clk_mhz = 250;
    localparam int blink_half_default = blink_half_ms * clk_mhz * 1000;
endpackage

/* File: sync2.sv */
`timescale 1ns/1ps
module sync2 #(parameter int width = 1) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [width-1:0] d,
    output logic [width-1:0] q
);
    logic [width-1:0] meta;
    logic [width-1:0] next_meta;
    logic [width-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule

/* File: blink_timer.sv */
`timescale 1ns/1ps
module blink_timer #(parameter int half_cycles = 4) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Shared blink phase
    output logic blink
);
    localparam int cw = (half_cycles > 1) ? $clog2(half_cycles) : 1;
    localparam logic [cw-1:0] last = cw'(half_cycles - 1);
    logic [cw-1:0] cnt;
    logic [cw-1:0] next_cnt;
    logic next_blink;

    // One counter for all LEDs keeps every flash in phase
    always_comb begin
        next_cnt = cnt + cw'(1);
        next_blink = blink;
        if (cnt == last) begin
            next_cnt = '0;
            next_blink = ~blink;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            blink <= 1'b0;
        end else begin
            cnt <= next_cnt;
            blink <= next_blink;
        end
    end
endmodule

/* File: combiner_status_led_logic.sv */
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module combiner_status_led_logic
    import combiner_pkg::*;
#(
    parameter int blink_half_cycles = blink_half_default
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Amplifier and combiner status pins
    input wire logic [2:0] amp_fault,
    input wire logic [2:0] amp_mute,
    input wire logic [2:0] amp_online,
    input wire logic switch_fault,
    input wire logic summary_fault,
    // Stored calibration gains, 0.01 dB units
    input wire logic [15:0] cal_gain1,
    input wire logic [15:0] cal_gain2,
    input wire logic [15:0] cal_gain3,
    // Indicators
    output logic summary_led_red,
    output logic summary_led_green,
    output logic [2:0] amp_led_red,
    output logic [2:0] amp_led_green,
    // Gain path controls
    output logic [2:0] amp_online_cmd,
    output logic [15:0] atten,
    output logic [15:0] amp_offset1,
    output logic [15:0] amp_offset2,
    output logic [15:0] amp_offset3,
    // Interrupt
    output logic irq
);
    typedef enum logic [1:0] {eq_idle, eq_min, eq_set} eq_state_t;

    logic [58:0] sync_q;
    logic [2:0] s_fault;
    logic [2:0] s_mute;
    logic [2:0] s_online;
    logic s_sw;
    logic s_sum;
    logic [2:0][15:0] s_gain;
    logic blink;

    // Inputs are sampled after two flops; gains must be steady on request
    sync2 #(.width(59)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({cal_gain3, cal_gain2, cal_gain1, summary_fault, switch_fault,
            amp_online, amp_mute, amp_fault}),
        .q(sync_q)
    );

    blink_timer #(.half_cycles(blink_half_cycles)) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .blink(blink)
    );

    assign s_fault = sync_q[2:0];
    assign s_mute = sync_q[5:3];
    assign s_online = sync_q[8:6];
    assign s_sw = sync_q[9];
    assign s_sum = sync_q[10];
    assign s_gain = sync_q[58:11];

    // Returns {red, green}; both lit means orange
    function automatic logic [1:0] amp_led(input logic fault, input logic mute,
                                           input logic online,
                                           input logic combine,
                                           input logic bl);
        logic [1:0] v;
        v = 2'b00;
        if (fault && online) begin
            v = 2'b10;
        end else if (fault) begin
            v = {bl, 1'b0};
        end else if (online) begin
            v = mute ? 2'b11 : 2'b01;
        end else if (!combine) begin
            v = mute ? {bl, bl} : {1'b0, bl};
        end
        return v;
    endfunction

    function automatic logic [2:0] pair_enable(input logic [7:0] v);
        logic [2:0] e;
        case (v)
            force_pair_12: e = pair_12_on;
            force_pair_13: e = pair_13_on;
            force_pair_23: e = pair_23_on;
            default: e = 3'h0;
        endcase
        return e;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= inputs_off);
    endfunction

    logic combine;
    logic [7:0] force_pair;
    logic [2:0][15:0] offs;
    logic [status_w-1:0] status;
    logic [status_w-1:0] mask;
    logic [2:0][15:0] gain;
    logic [15:0] gmin;
    eq_state_t eq_state;
    logic [2:0] prev_fault;
    logic prev_sw;
    logic prev_sum;

    logic next_combine;
    logic [7:0] next_force_pair;
    logic [15:0] next_atten;
    logic [2:0][15:0] next_offs;
    logic [status_w-1:0] next_status;
    logic [status_w-1:0] next_mask;
    logic [2:0][15:0] next_gain;
    logic [15:0] next_gmin;
    eq_state_t next_eq_state;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic next_sum_red;
    logic next_sum_green;
    logic [2:0] next_amp_red;
    logic [2:0] next_amp_green;
    logic [2:0] next_online_cmd;

    logic setup;
    logic wr;
    logic rd;
    logic eq_start;
    logic eq_done;
    logic [status_w-1:0] events;
    logic [31:0] rd_value;
    logic [15:0] min01;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign rd = psel & penable & pready & ~pwrite;
    assign eq_start = wr && paddr == equalize_off && pwdata[start_bit]
                      && eq_state == eq_idle;
    assign eq_done = eq_state == eq_set;
    assign events = {eq_done, s_fault & ~prev_fault, s_sum & ~prev_sum,
                     s_sw & ~prev_sw};
    assign min01 = (gain[1] < gain[0]) ? gain[1] : gain[0];

    always_comb begin
        rd_value = 32'h0000_0000;
        case (paddr)
            ctrl_off: rd_value[combine_bit] = combine;
            force_off: rd_value[7:0] = force_pair;
            atten_off: rd_value[15:0] = atten;
            offset1_off: rd_value[15:0] = offs[0];
            offset2_off: rd_value[15:0] = offs[1];
            offset3_off: rd_value[15:0] = offs[2];
            equalize_off: rd_value[start_bit] = eq_state != eq_idle;
            status_off: rd_value[status_w-1:0] = status;
            mask_off: rd_value[status_w-1:0] = mask;
            inputs_off: rd_value[10:0] = sync_q[10:0];
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_combine = combine;
        next_force_pair = force_pair;
        next_atten = atten;
        next_offs = offs;
        next_mask = mask;
        next_gain = gain;
        next_gmin = gmin;
        next_eq_state = eq_state;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        // Answer one cycle after setup: zero wait states
        if (setup) begin
            next_pready = 1'b1;
            next_prdata = pwrite ? 32'h0000_0000 : rd_value;
            next_pslverr = !addr_ok(paddr)
                           || (pwrite && paddr == force_off
                               && pair_enable(pwdata[7:0]) == 3'h0);
        end
        if (wr) begin
            case (paddr)
                ctrl_off: next_combine = pwdata[combine_bit];
                force_off: begin
                    if (pair_enable(pwdata[7:0]) != 3'h0) begin
                        next_force_pair = pwdata[7:0];
                    end
                end
                atten_off: next_atten = pwdata[15:0];
                offset1_off: next_offs[0] = pwdata[15:0];
                offset2_off: next_offs[1] = pwdata[15:0];
                offset3_off: next_offs[2] = pwdata[15:0];
                mask_off: next_mask = pwdata[status_w-1:0];
                default: next_mask = mask;
            endcase
        end
        // Equalizer overrides a same-cycle offset write
        case (eq_state)
            eq_idle: begin
                if (eq_start) begin
                    next_gain = s_gain;
                    next_eq_state = eq_min;
                end
            end
            eq_min: begin
                next_gmin = (gain[2] < min01) ? gain[2] : min01;
                next_eq_state = eq_set;
            end
            eq_set: begin
                for (int i = 0; i < 3; i++) begin
                    next_offs[i] = gain[i] - gmin;
                end
                next_eq_state = eq_idle;
            end
            default: next_eq_state = eq_idle;
        endcase
        // A new event beats the read that clears the flag
        if (rd && paddr == status_off) begin
            next_status = events;
        end else begin
            next_status = status | events;
        end
        next_irq = |(next_status & next_mask);
        next_online_cmd = pair_enable(next_force_pair);
        next_sum_green = !s_sw && !s_sum;
        next_sum_red = s_sw ? blink : s_sum;
        for (int i = 0; i < 3; i++) begin
            {next_amp_red[i], next_amp_green[i]} =
                amp_led(s_fault[i], s_mute[i], s_online[i], combine, blink);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            combine <= ctrl_reset;
            force_pair <= force_reset;
            atten <= atten_reset;
            offs <= {3{offset_reset}};
            status <= '0;
            mask <= mask_reset;
            gain <= '0;
            gmin <= 16'h0000;
            eq_state <= eq_idle;
            prev_fault <= 3'h0;
            prev_sw <= 1'b0;
            prev_sum <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
            summary_led_red <= 1'b0;
            summary_led_green <= 1'b0;
            amp_led_red <= 3'h0;
            amp_led_green <= 3'h0;
            amp_online_cmd <= pair_12_on;
        end else begin
            combine <= next_combine;
            force_pair <= next_force_pair;
            atten <= next_atten;
            offs <= next_offs;
            status <= next_status;
            mask <= next_mask;
            gain <= next_gain;
            gmin <= next_gmin;
            eq_state <= next_eq_state;
            prev_fault <= s_fault;
            prev_sw <= s_sw;
            prev_sum <= s_sum;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
            summary_led_red <= next_sum_red;
            summary_led_green <= next_sum_green;
            amp_led_red <= next_amp_red;
            amp_led_green <= next_amp_green;
            amp_online_cmd <= next_online_cmd;
        end
    end

    assign amp_offset1 = offs[0];
    assign amp_offset2 = offs[1];
    assign amp_offset3 = offs[2];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence eq_run_s;
        eq_start ##1 eq_state == eq_min ##1 eq_state == eq_set;
    endsequence

    sequence atten_zero_s;
        wr && paddr == atten_off && pwdata[15:0] == 16'h0000
            && eq_state == eq_idle;
    endsequence

    sum_green_a: assert property (!s_sw && !s_sum |=> summary_led_green
        && !summary_led_red) else $error("summary not green");
    sum_blink_a: assert property (s_sw |=> summary_led_red == $past(blink)
        && !summary_led_green) else $error("switch blink wrong");
    sum_steady_a: assert property (!s_sw && s_sum |=> summary_led_red
        && !summary_led_green) else $error("summary not red");
    amp_green_a: assert property (!s_fault[0] && !s_mute[0] && s_online[0]
        |=> !amp_led_red[0] && amp_led_green[0])
        else $error("amp green wrong");
    amp_orange_a: assert property (!s_fault[1] && s_mute[1] && s_online[1]
        |=> amp_led_red[1] && amp_led_green[1])
        else $error("amp orange wrong");
    amp_red_a: assert property (s_fault[2] && s_online[2]
        |=> amp_led_red[2] && !amp_led_green[2])
        else $error("amp red wrong");
    amp_red_blink_a: assert property (s_fault[0] && !s_online[0]
        |=> amp_led_red[0] == $past(blink) && !amp_led_green[0])
        else $error("amp red blink wrong");
    offline_green_a: assert property (!combine && !s_fault[1] && !s_mute[1]
        && !s_online[1] |=> amp_led_green[1] == $past(blink)
        && !amp_led_red[1]) else $error("offline green wrong");
    offline_orange_a: assert property (!combine && !s_fault[2] && s_mute[2]
        && !s_online[2] |=> amp_led_green[2] == $past(blink)
        && amp_led_red[2] == $past(blink))
        else $error("offline orange wrong");
    combine_dark_a: assert property (combine && !s_fault[1]
        && !s_online[1] |=> amp_led_red[1] == 1'b0
        && amp_led_green[1] == 1'b0)
        else $error("combine offline lit");
    force_13_a: assert property (wr && paddr == force_off
        && pwdata[7:0] == force_pair_13 |=> amp_online_cmd == pair_13_on
        && force_pair == force_pair_13)
        else $error("force 13 wrong");
    force_bad_a: assert property (wr && paddr == force_off
        && pair_enable(pwdata[7:0]) == 3'h0 |=> $stable(force_pair))
        else $error("bad force stored");
    force_read_a: assert property (setup && !pwrite && paddr == force_off
        |=> pready && prdata == {24'h00_0000, force_pair})
        else $error("force query wrong");
    offset_read_a: assert property (setup && !pwrite
        && paddr == offset2_off && eq_state == eq_idle
        |=> prdata == {16'h0000, offs[1]})
        else $error("offset query wrong");
    atten_zero_a: assert property (atten_zero_s |=> atten == 16'h0000
        && $stable(offs)) else $error("attenuation zero wrong");
    blink_phase_a: assert property (s_sw && s_fault[0] && !s_online[0]
        |=> amp_led_red[0] == summary_led_red)
        else $error("blinks out of phase");
    equalize_a: assert property (eq_run_s |=> (offs[0] == 16'h0000
        || offs[1] == 16'h0000 || offs[2] == 16'h0000)
        && offs[0] == gain[0] - gmin)
        else $error("equalize wrong");
endmodule

/* File: amp_pins_model.sv */
`timescale 1ns/1ps
module amp_pins_model (
    // Clock
    input wire logic pclk,
    // Conditions asked for by the bench
    input wire logic [2:0] want_fault,
    input wire logic [2:0] want_mute,
    input wire logic [2:0] want_online,
    input wire logic want_switch,
    input wire logic want_summary,
    input wire logic [15:0] want_gain1,
    input wire logic [15:0] want_gain2,
    input wire logic [15:0] want_gain3,
    // Pins toward the combiner
    output logic [2:0] amp_fault,
    output logic [2:0] amp_mute,
    output logic [2:0] amp_online,
    output logic switch_fault,
    output logic summary_fault,
    output logic [15:0] cal_gain1,
    output logic [15:0] cal_gain2,
    output logic [15:0] cal_gain3
);
    // Amplifiers report levels that only move after a clock edge
    always @(posedge pclk) begin
        amp_fault <= want_fault;
        amp_mute <= want_mute;
        amp_online <= want_online;
        switch_fault <= want_switch;
        summary_fault <= want_summary;
        cal_gain1 <= want_gain1;
        cal_gain2 <= want_gain2;
        cal_gain3 <= want_gain3;
    end
endmodule

/* File: tb_combiner_status_led_logic.sv */
`timescale 1ns/1ps
module tb_combiner_status_led_logic;
    import combiner_pkg::*;
    localparam logic [1:0] dark = 2'b01;
    localparam logic [1:0] lit = 2'b10;
    localparam logic [1:0] blk = 2'b11;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er;
    logic [2:0] wf = 3'h0, wm = 3'h0, wo = 3'h7;
    logic wsw = 1'b0, wsu = 1'b0;
    logic [15:0] g1 = 16'h1d4c, g2 = 16'h1c84, g3 = 16'h1db0;
    logic [2:0] amp_fault, amp_mute, amp_online, amp_led_red, amp_led_green;
    logic [2:0] amp_online_cmd;
    logic switch_fault, summary_fault, summary_led_red, summary_led_green;
    logic [15:0] cal_gain1, cal_gain2, cal_gain3;
    logic [15:0] atten, amp_offset1, amp_offset2, amp_offset3;
    logic irq;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;

    always #2 pclk = ~pclk;

    amp_pins_model pins (.pclk(pclk), .want_fault(wf), .want_mute(wm),
        .want_online(wo), .want_switch(wsw), .want_summary(wsu),
        .want_gain1(g1), .want_gain2(g2), .want_gain3(g3),
        .amp_fault(amp_fault), .amp_mute(amp_mute), .amp_online(amp_online),
        .switch_fault(switch_fault), .summary_fault(summary_fault),
        .cal_gain1(cal_gain1), .cal_gain2(cal_gain2), .cal_gain3(cal_gain3));

    combiner_status_led_logic #(.blink_half_cycles(4)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .amp_fault(amp_fault), .amp_mute(amp_mute),
        .amp_online(amp_online), .switch_fault(switch_fault),
        .summary_fault(summary_fault), .cal_gain1(cal_gain1),
        .cal_gain2(cal_gain2), .cal_gain3(cal_gain3),
        .summary_led_red(summary_led_red),
        .summary_led_green(summary_led_green), .amp_led_red(amp_led_red),
        .amp_led_green(amp_led_green), .amp_online_cmd(amp_online_cmd),
        .atten(atten), .amp_offset1(amp_offset1), .amp_offset2(amp_offset2),
        .amp_offset3(amp_offset3), .irq(irq));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs a few hundred cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge pclk);
    endtask

    // Wait for pready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sorts each colour into dark, lit or blinking over 12 cycles
    task automatic watch(input int k, output logic [1:0] r,
                         output logic [1:0] g);
        logic rv, gv;
        r = 2'b00;
        g = 2'b00;
        repeat (12) begin
            @(negedge pclk);
            rv = (k == 0) ? summary_led_red : amp_led_red[k-1];
            gv = (k == 0) ? summary_led_green : amp_led_green[k-1];
            r = r | ((rv === 1'b1) ? 2'b10 : 2'b01);
            g = g | ((gv === 1'b1) ? 2'b10 : 2'b01);
        end
    endtask

    task automatic led_case(input int k, input logic [2:0] f, m, o,
                            input logic sw, su, input logic [1:0] er_, eg);
        logic [1:0] r, g;
        @(posedge pclk);
        wf <= f;
        wm <= m;
        wo <= o;
        wsw <= sw;
        wsu <= su;
        idle(6);
        watch(k, r, g);
        check(r, er_);
        check(g, eg);
    endtask

    task automatic reset_values();
        check(amp_online_cmd, 3'b011);
        check(irq, 1'b0);
        apb(1'b0, ctrl_off, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        apb(1'b0, force_off, 32'h0000_0000);
        check(rd, 32'h0000_000c);
    endtask

    task automatic force_pairs();
        logic [7:0] v[3] = '{force_pair_12, force_pair_13, force_pair_23};
        logic [2:0] on[3] = '{3'b011, 3'b101, 3'b110};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, force_off, {24'h00_0000, v[i]});
            check(er, 1'b0);
            idle(2);
            check(amp_online_cmd, on[i]);
            apb(1'b0, force_off, 32'h0000_0000);
            check(rd, {24'h00_0000, v[i]});
        end
        apb(1'b1, force_off, 32'h0000_000e);
        check(er, 1'b1);
        apb(1'b0, force_off, 32'h0000_0000);
        check(rd, 32'h0000_0017);
        check(amp_online_cmd, 3'b110);
        apb(1'b0, 8'h28, 32'h0000_0000);
        check(er, 1'b1);
        check(rd, 32'h0000_0000);
    endtask

    task automatic leds();
        int i;
        led_case(0, 3'h0, 3'h0, 3'h7, 1'b0, 1'b0, dark, lit);
        led_case(0, 3'h0, 3'h0, 3'h7, 1'b1, 1'b1, blk, dark);
        led_case(0, 3'h0, 3'h0, 3'h7, 1'b0, 1'b1, lit, dark);
        for (i = 0; i < 2; i++) begin
            apb(1'b1, ctrl_off, {31'h0000_0000, i[0]});
            led_case(1, 3'h0, 3'h0, 3'h7, 1'b0, 1'b0, dark, lit);
            led_case(2, 3'h0, 3'h2, 3'h7, 1'b0, 1'b0, lit, lit);
            led_case(3, 3'h4, 3'h0, 3'h7, 1'b0, 1'b0, lit, dark);
            led_case(1, 3'h1, 3'h0, 3'h6, 1'b0, 1'b0, blk, dark);
        end
        led_case(2, 3'h0, 3'h0, 3'h5, 1'b0, 1'b0, dark, dark);
        apb(1'b1, ctrl_off, 32'h0000_0000);
        led_case(2, 3'h0, 3'h0, 3'h5, 1'b0, 1'b0, dark, blk);
        led_case(3, 3'h0, 3'h4, 3'h3, 1'b0, 1'b0, blk, blk);
        led_case(1, 3'h1, 3'h4, 3'h2, 1'b1, 1'b0, blk, dark);
        repeat (10) begin
            @(negedge pclk);
            check(amp_led_red[0], summary_led_red);
            check(amp_led_red[2], amp_led_green[2]);
        end
        check(irq, 1'b0);
        apb(1'b0, status_off, 32'h0000_0000);
        check(rd, 32'h0000_0017);
        apb(1'b0, inputs_off, 32'h0000_0000);
        check(rd, 32'h0000_02a1);
    endtask

    task automatic offsets();
        logic [7:0] a[3] = '{offset1_off, offset2_off, offset3_off};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, a[i], 32'h0000_0100 + i);
        end
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, a[i], 32'h0000_0000);
            check(rd, 32'h0000_0100 + i);
        end
        apb(1'b1, atten_off, 32'h0000_0123);
        idle(1);
        check(atten, 16'h0123);
        apb(1'b1, atten_off, 32'h0000_0000);
        idle(1);
        check(atten, 16'h0000);
        check({amp_offset1, amp_offset2}, 32'h0100_0101);
        check(amp_offset3, 16'h0102);
    endtask

    task automatic equalize();
        int n;
        apb(1'b1, mask_off, 32'h0000_0020);
        apb(1'b1, equalize_off, 32'h0000_0001);
        n = 0;
        do begin
            apb(1'b0, equalize_off, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        idle(1);
        check(amp_offset1, 16'h00c8);
        check(amp_offset2, 16'h0000);
        check(amp_offset3, 16'h012c);
        check(irq, 1'b1);
        apb(1'b0, status_off, 32'h0000_0000);
        check(rd & 32'h0000_0020, 32'h0000_0020);
        idle(1);
        check(irq, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        idle(1);
        reset_values();
        force_pairs();
        leds();
        offsets();
        equalize();
        wrap_up();
    end
endmodule
